// ===== pd_message_applicability.sv
// Message applicability and response policy with APB registers
// Notes on behaviour
// - Unsupported messages are never sent; tx_ok stays low and the ev_txblk status bit is set.
// - Reject-class received messages are answered with a Reject message.
// - NAK-class received vendor commands are answered with a Responder NAK.
// - Ignore/reject/NAK only in ready states; unexpected mid-sequence is error.
// - A supported message brings its action, e.g. GotoMin reduces current.
// - Hub or host sources with several downstream ports send GotoMin; others optional.
// - FSK sources send Ping; other sources optional; sinks and plugs never.
// - A source able to send GotoMin can also send Wait.
// - Charging sinks act on GotoMin; sources and cable plugs ignore it.
// - Dual data role ports send and accept data-role swaps; others reject.
// - Supply-conductor swap accepted only with high-speed pins and role swap.
// - Modal operation overrides plain port rules for vendor commands.
// - Only a downstream port initiates SVID/mode discovery, entry and exit commands.
// - Upstream ports and plugs answer those commands; downstream ignores.
// - Upstream sources may send identity discovery; plugs must answer it.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
module pd_message_applicability (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire pd_msg_pkg::rx_s    rx,
   output pd_msg_pkg::rsp_s        rsp,
   output logic                    gotomin_act,
   input  wire logic               tx_req,
   input  wire pd_msg_pkg::msg_e   tx_code,
   output logic                    tx_done,
   output logic                    tx_ok,
   output logic                    irq
);

   typedef pd_msg_pkg::msg_e msg_t;
   typedef pd_msg_pkg::act_e act_t;
   typedef pd_msg_pkg::cfg_s cfg_t;

   cfg_t                         cfg_q;
   logic [pd_msg_pkg::ev_num-1:0] int_sta_q;
   logic [pd_msg_pkg::ev_num-1:0] int_en_q;
   logic [pd_msg_pkg::ev_num-1:0] ev;
   pd_msg_pkg::rsp_s             rsp_q;
   logic                         gotomin_q;
   logic                         tx_done_q;
   logic                         tx_ok_q;
   logic [31:0]                  prdata_q;

   // Allowed to transmit this code in the given configuration
   function automatic logic tx_allowed(input msg_t c, input cfg_t f);
      logic src;
      logic snk;
      logic drp;
      logic dfp;
      logic ufp;
      logic go;
      src = (f.pwr_role == pd_msg_pkg::pwr_src);
      snk = (f.pwr_role == pd_msg_pkg::pwr_snk);
      drp = (f.pwr_role == pd_msg_pkg::pwr_drp);
      dfp = (f.data_role == pd_msg_pkg::dat_dfp) ||
            (f.data_role == pd_msg_pkg::dat_drd && !f.cur_ufp);
      ufp = !dfp;
      go  = src && (f.hub_multi || f.host_multi || f.opt_tx);
      if (f.cable) begin
         tx_allowed = (c == pd_msg_pkg::m_goodcrc) ||
                      (c == pd_msg_pkg::m_accept);
      end else begin
         case (c)
            pd_msg_pkg::m_goodcrc,
            pd_msg_pkg::m_accept,
            pd_msg_pkg::m_reject,
            pd_msg_pkg::m_soft_reset,
            pd_msg_pkg::m_get_src_cap,
            pd_msg_pkg::m_get_snk_cap,
            pd_msg_pkg::m_vconn_swap,
            pd_msg_pkg::m_bist:     tx_allowed = 1'b1;
            pd_msg_pkg::m_gotomin:  tx_allowed = go;
            pd_msg_pkg::m_ping:     tx_allowed = src &&
                                       (f.bfsk || f.opt_tx);
            pd_msg_pkg::m_ps_rdy,
            pd_msg_pkg::m_src_cap:  tx_allowed = src || drp;
            pd_msg_pkg::m_pr_swap:  tx_allowed = drp;
            pd_msg_pkg::m_wait:     tx_allowed = go || ((src || drp ||
               f.data_role == pd_msg_pkg::dat_drd) && f.opt_tx);
            pd_msg_pkg::m_dr_swap:  tx_allowed =
               (f.data_role == pd_msg_pkg::dat_drd);
            pd_msg_pkg::m_request,
            pd_msg_pkg::m_snk_cap:  tx_allowed = snk || drp;
            pd_msg_pkg::v_disc_id:  tx_allowed = dfp ||
                                       (ufp && !snk);
            pd_msg_pkg::v_disc_svid,
            pd_msg_pkg::v_disc_modes,
            pd_msg_pkg::v_enter,
            pd_msg_pkg::v_exit:     tx_allowed = f.modal && dfp;
            pd_msg_pkg::v_attention: tx_allowed = ufp;
            default:                tx_allowed = 1'b0;
         endcase
      end
   endfunction : tx_allowed

   // Response class of a received code in a ready state
   function automatic act_t rx_class(input msg_t c, input cfg_t f);
      logic src;
      logic snk;
      logic drp;
      logic dfp;
      logic vdm;
      src = (f.pwr_role == pd_msg_pkg::pwr_src) ||
            (f.pwr_role == pd_msg_pkg::pwr_drp && !f.cur_snk);
      snk = !src;
      drp = (f.pwr_role == pd_msg_pkg::pwr_drp);
      dfp = (f.data_role == pd_msg_pkg::dat_dfp) ||
            (f.data_role == pd_msg_pkg::dat_drd && !f.cur_ufp);
      vdm = (c >= pd_msg_pkg::v_disc_id) &&
            (c <= pd_msg_pkg::v_exit);
      rx_class = pd_msg_pkg::a_ignore;
      if (f.cable) begin
         case (c)
            pd_msg_pkg::m_goodcrc,
            pd_msg_pkg::m_soft_reset,
            pd_msg_pkg::m_bist,
            pd_msg_pkg::v_disc_id:   rx_class = pd_msg_pkg::a_handle;
            pd_msg_pkg::v_disc_svid,
            pd_msg_pkg::v_disc_modes,
            pd_msg_pkg::v_enter,
            pd_msg_pkg::v_exit:      rx_class = f.modal ?
               pd_msg_pkg::a_handle : pd_msg_pkg::a_nak;
            default:                 rx_class = pd_msg_pkg::a_ignore;
         endcase
      end else if (vdm && f.modal) begin
         rx_class = dfp ? pd_msg_pkg::a_ignore :
                          pd_msg_pkg::a_handle;
      end else begin
         case (c)
            pd_msg_pkg::m_goodcrc,
            pd_msg_pkg::m_accept,
            pd_msg_pkg::m_reject,
            pd_msg_pkg::m_soft_reset,
            pd_msg_pkg::m_bist:      rx_class = pd_msg_pkg::a_handle;
            pd_msg_pkg::m_gotomin:   rx_class = (snk && f.charging) ?
               pd_msg_pkg::a_handle : pd_msg_pkg::a_ignore;
            pd_msg_pkg::m_ps_rdy,
            pd_msg_pkg::m_wait,
            pd_msg_pkg::m_src_cap:   rx_class = snk ?
               pd_msg_pkg::a_handle : pd_msg_pkg::a_ignore;
            pd_msg_pkg::m_request:   rx_class = src ?
               pd_msg_pkg::a_handle : pd_msg_pkg::a_ignore;
            pd_msg_pkg::m_snk_cap:   rx_class = (src || drp) ?
               pd_msg_pkg::a_handle : pd_msg_pkg::a_ignore;
            pd_msg_pkg::m_get_src_cap: rx_class = (drp ||
               f.pwr_role == pd_msg_pkg::pwr_src) ?
               pd_msg_pkg::a_handle : pd_msg_pkg::a_reject;
            pd_msg_pkg::m_get_snk_cap: rx_class = (drp ||
               f.pwr_role == pd_msg_pkg::pwr_snk) ?
               pd_msg_pkg::a_handle : pd_msg_pkg::a_reject;
            pd_msg_pkg::m_pr_swap:   rx_class = drp ?
               pd_msg_pkg::a_handle : pd_msg_pkg::a_reject;
            pd_msg_pkg::m_dr_swap:   rx_class =
               (f.data_role == pd_msg_pkg::dat_drd) ?
               pd_msg_pkg::a_handle : pd_msg_pkg::a_reject;
            pd_msg_pkg::m_vconn_swap: rx_class = (f.ss_pins && drp) ?
               pd_msg_pkg::a_handle : pd_msg_pkg::a_reject;
            pd_msg_pkg::v_disc_id:   rx_class = dfp ?
               pd_msg_pkg::a_ignore : (f.ident_rx ?
               pd_msg_pkg::a_handle : pd_msg_pkg::a_nak);
            pd_msg_pkg::v_disc_svid,
            pd_msg_pkg::v_disc_modes,
            pd_msg_pkg::v_enter,
            pd_msg_pkg::v_exit:      rx_class = dfp ?
               pd_msg_pkg::a_ignore : pd_msg_pkg::a_nak;
            pd_msg_pkg::v_attention: rx_class = dfp ? (f.attn_rx ?
               pd_msg_pkg::a_handle : pd_msg_pkg::a_ignore) :
               pd_msg_pkg::a_nak;
            default:                 rx_class = pd_msg_pkg::a_ignore;
         endcase
      end
   endfunction : rx_class

   // Receive decision
   act_t rx_act;
   act_t rx_cls;
   assign rx_cls = rx_class(rx.code, cfg_q);
   assign rx_act = rx.ready ? rx_cls :
                   (rx.expected ? pd_msg_pkg::a_handle :
                                  pd_msg_pkg::a_perr);

   // APB decode
   logic apb_wr;
   logic apb_rd;
   logic hit_cfg;
   logic hit_last;
   logic hit_sta;
   logic hit_en;
   logic hit_clr;
   logic hit_any;
   logic [31:0] rd_mux;
   assign apb_wr   = psel && penable && pwrite;
   assign apb_rd   = psel && !penable && !pwrite;
   assign hit_cfg  = (paddr == pd_msg_pkg::cfg_off);
   assign hit_last = (paddr == pd_msg_pkg::last_off);
   assign hit_sta  = (paddr == pd_msg_pkg::int_sta_off);
   assign hit_en   = (paddr == pd_msg_pkg::int_en_off);
   assign hit_clr  = (paddr == pd_msg_pkg::int_clr_off);
   assign hit_any  = hit_cfg || hit_last || hit_sta || hit_en || hit_clr;
   assign rd_mux   = hit_cfg  ? {16'h0000, cfg_q} :
                     hit_last ? {23'h000000, rsp_q} :
                     hit_sta  ? {27'h0000000, int_sta_q} :
                     hit_en   ? {27'h0000000, int_en_q} : 32'h00000000;
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !hit_any;
   assign prdata   = prdata_q;

   // Events that set sticky status bits
   logic tx_blk;
   assign tx_blk = tx_req && !tx_allowed(tx_code, cfg_q);
   assign ev[pd_msg_pkg::ev_ignore] = rx.valid &&
                                      rx_act == pd_msg_pkg::a_ignore;
   assign ev[pd_msg_pkg::ev_reject] = rx.valid &&
                                      rx_act == pd_msg_pkg::a_reject;
   assign ev[pd_msg_pkg::ev_nak]    = rx.valid &&
                                      rx_act == pd_msg_pkg::a_nak;
   assign ev[pd_msg_pkg::ev_perr]   = rx.valid &&
                                      rx_act == pd_msg_pkg::a_perr;
   assign ev[pd_msg_pkg::ev_txblk]  = tx_blk;

   logic [pd_msg_pkg::ev_num-1:0] clr_mask;
   assign clr_mask = (apb_wr && hit_clr) ?
                     pwdata[pd_msg_pkg::ev_num-1:0] : '0;
   assign irq = |(int_sta_q & int_en_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q    <= pd_msg_pkg::cfg_rst;
         int_en_q <= pd_msg_pkg::int_en_rst;
      end else if (apb_wr && hit_cfg) begin
         cfg_q    <= cfg_t'(pwdata[15:0]);
      end else if (apb_wr && hit_en) begin
         int_en_q <= pwdata[pd_msg_pkg::ev_num-1:0];
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_sta_q <= '0;
      end else begin
         int_sta_q <= (int_sta_q & ~clr_mask) | ev;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
      end else if (apb_rd) begin
         prdata_q <= rd_mux;
      end
   end

   // Response and transmit gate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsp_q     <= '0;
         gotomin_q <= 1'b0;
         tx_done_q <= 1'b0;
         tx_ok_q   <= 1'b0;
      end else begin
         rsp_q.valid <= rx.valid;
         if (rx.valid) begin
            rsp_q.act  <= rx_act;
            rsp_q.code <= rx.code;
         end
         gotomin_q <= rx.valid && rx.code == pd_msg_pkg::m_gotomin &&
                      rx_act == pd_msg_pkg::a_handle;
         tx_done_q <= tx_req;
         tx_ok_q   <= tx_req && !tx_blk;
      end
   end

   assign rsp         = rsp_q;
   assign gotomin_act = gotomin_q;
   assign tx_done     = tx_done_q;
   assign tx_ok       = tx_ok_q;

   // Checks
   rej_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
      rx.valid && rx.ready && rx_cls == pd_msg_pkg::a_reject |=>
      rsp.valid && rsp.act == pd_msg_pkg::a_reject)
      else $error("reject class not answered");
   nak_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
      rx.valid && rx.ready && rx_cls == pd_msg_pkg::a_nak |=>
      rsp.act == pd_msg_pkg::a_nak)
      else $error("nak class not answered");
   mid_seq_a: assert property (@(posedge pclk) disable iff (!presetn)
      rx.valid && !rx.ready && !rx.expected |=>
      rsp.valid && rsp.act == pd_msg_pkg::a_perr)
      else $error("unexpected message not a protocol error");
   ping_snk_a: assert property (@(posedge pclk) disable iff (!presetn)
      tx_req && tx_code == pd_msg_pkg::m_ping &&
      cfg_q.pwr_role != pd_msg_pkg::pwr_src |=> tx_done && !tx_ok)
      else $error("ping sent by non-source");
   hub_goto_a: assert property (@(posedge pclk) disable iff (!presetn)
      tx_req && !cfg_q.cable && cfg_q.hub_multi &&
      cfg_q.pwr_role == pd_msg_pkg::pwr_src &&
      (tx_code == pd_msg_pkg::m_gotomin ||
       tx_code == pd_msg_pkg::m_wait) |=> tx_ok)
      else $error("hub source blocked from gotomin or wait");
   goto_act_a: assert property (@(posedge pclk) disable iff (!presetn)
      gotomin_act |-> $past(rx.code) == pd_msg_pkg::m_gotomin &&
      !$past(cfg_q.cable) && $past(cfg_q.charging))
      else $error("gotomin acted on wrongly");
   plug_tx_a: assert property (@(posedge pclk) disable iff (!presetn)
      tx_ok && $past(cfg_q.cable) |->
      $past(tx_code) == pd_msg_pkg::m_goodcrc ||
      $past(tx_code) == pd_msg_pkg::m_accept)
      else $error("cable plug sent a forbidden message");
   drswap_a: assert property (@(posedge pclk) disable iff (!presetn)
      rx.valid && rx.ready && rx.code == pd_msg_pkg::m_dr_swap &&
      !cfg_q.cable && cfg_q.data_role != pd_msg_pkg::dat_drd |=>
      rsp.act == pd_msg_pkg::a_reject)
      else $error("single data role did not reject swap");
   sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
      ev[pd_msg_pkg::ev_reject] |=> int_sta_q[pd_msg_pkg::ev_reject])
      else $error("reject event lost");

endmodule : pd_message_applicability

// ===== pd_message_applicability_tb.sv
// Self-checking bench for the message applicability block
`timescale 1ns/10ps
module pd_message_applicability_tb;
   typedef struct packed {
      logic             tx;
      logic [15:0]      cfg;
      pd_msg_pkg::msg_e code;
      logic [2:0]       res;
   } row_s;

   logic             pclk;
   logic             presetn;
   logic             psel;
   logic             penable;
   logic             pwrite;
   logic [7:0]       paddr;
   logic [31:0]      pwdata;
   logic [31:0]      prdata;
   logic             pready;
   logic             pslverr;
   pd_msg_pkg::rx_s  rx;
   pd_msg_pkg::rsp_s rsp;
   logic             gotomin_act;
   logic             tx_req;
   pd_msg_pkg::msg_e tx_code;
   logic             tx_done;
   logic             tx_ok;
   logic             irq;
   row_s             rows[$];
   int               n_fail;
   int               tests_run;
   int               n_gm;
   logic [31:0]      rd;
   logic             err;
   pd_msg_pkg::rsp_s r;

   pd_message_applicability i_pd_message_applicability (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx(rx), .rsp(rsp),
      .gotomin_act(gotomin_act), .tx_req(tx_req), .tx_code(tx_code),
      .tx_done(tx_done), .tx_ok(tx_ok), .irq(irq));

   pd_remote_port i_pd_remote_port (.pclk(pclk), .rx(rx), .rsp(rsp));

   always #2 pclk = ~pclk;

   always @(posedge pclk) begin
      if (gotomin_act === 1'b1) n_gm <= n_gm + 1;
   end

   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 16) begin
         n_fail++;
         give_verdict();
      end
   endtask : apb

   function automatic void add(input logic t, input logic [15:0] c,
                               input pd_msg_pkg::msg_e m,
                               input logic [2:0] e);
      rows.push_back('{t, c, m, e});
   endfunction : add

   initial begin
      repeat (100000) @(posedge pclk);
      n_fail++;
      give_verdict();
   end

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      tx_req = 1'b0;
      tx_code = pd_msg_pkg::m_goodcrc;
      n_fail = 0;
      tests_run = 0;
      n_gm = 0;
      add(0, 16'h0000, pd_msg_pkg::m_get_snk_cap, pd_msg_pkg::a_reject);
      add(0, 16'h0000, pd_msg_pkg::m_pr_swap, pd_msg_pkg::a_reject);
      add(0, 16'h0000, pd_msg_pkg::m_gotomin, pd_msg_pkg::a_ignore);
      add(0, 16'h0000, pd_msg_pkg::m_ping, pd_msg_pkg::a_ignore);
      add(0, 16'h0000, pd_msg_pkg::m_dr_swap, pd_msg_pkg::a_reject);
      add(0, 16'h0000, pd_msg_pkg::v_enter, pd_msg_pkg::a_ignore);
      add(0, 16'h0000, pd_msg_pkg::m_ps_rdy, pd_msg_pkg::a_ignore);
      add(0, 16'h0005, pd_msg_pkg::m_get_src_cap, pd_msg_pkg::a_reject);
      add(0, 16'h0005, pd_msg_pkg::v_disc_svid, pd_msg_pkg::a_nak);
      add(0, 16'h0005, pd_msg_pkg::m_ps_rdy, pd_msg_pkg::a_handle);
      add(0, 16'h0105, pd_msg_pkg::m_gotomin, pd_msg_pkg::a_handle);
      add(0, 16'h000a, pd_msg_pkg::m_pr_swap, pd_msg_pkg::a_handle);
      add(0, 16'h000a, pd_msg_pkg::m_dr_swap, pd_msg_pkg::a_handle);
      add(0, 16'h1002, pd_msg_pkg::m_vconn_swap, pd_msg_pkg::a_handle);
      add(0, 16'h0000, pd_msg_pkg::m_vconn_swap, pd_msg_pkg::a_reject);
      add(0, 16'h0040, pd_msg_pkg::m_request, pd_msg_pkg::a_ignore);
      add(0, 16'h0040, pd_msg_pkg::m_soft_reset, pd_msg_pkg::a_handle);
      add(0, 16'h0040, pd_msg_pkg::v_disc_svid, pd_msg_pkg::a_nak);
      add(0, 16'h0085, pd_msg_pkg::v_enter, pd_msg_pkg::a_handle);
      add(1, 16'h0000, pd_msg_pkg::m_ping, 3'h0);
      add(1, 16'h0800, pd_msg_pkg::m_ping, 3'h1);
      add(1, 16'h0005, pd_msg_pkg::m_ping, 3'h0);
      add(1, 16'h0200, pd_msg_pkg::m_gotomin, 3'h1);
      add(1, 16'h0200, pd_msg_pkg::m_wait, 3'h1);
      add(1, 16'h0000, pd_msg_pkg::m_gotomin, 3'h0);
      add(1, 16'h0040, pd_msg_pkg::m_accept, 3'h1);
      add(1, 16'h0040, pd_msg_pkg::m_reject, 3'h0);
      add(1, 16'h0000, pd_msg_pkg::m_ps_rdy, 3'h1);
      add(1, 16'h0005, pd_msg_pkg::m_ps_rdy, 3'h0);
      add(1, 16'h0080, pd_msg_pkg::v_enter, 3'h1);
      add(1, 16'h0085, pd_msg_pkg::v_enter, 3'h0);
      add(1, 16'h000a, pd_msg_pkg::m_dr_swap, 3'h1);
      add(1, 16'h0000, pd_msg_pkg::m_dr_swap, 3'h0);
      add(1, 16'h0005, pd_msg_pkg::m_goodcrc, 3'h1);
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, pd_msg_pkg::cfg_off, 32'h0);
      chk("cfg reset", {16'h0, pd_msg_pkg::cfg_rst}, rd);
      apb(0, pd_msg_pkg::int_en_off, 32'h0);
      chk("enable reset", {27'h0, pd_msg_pkg::int_en_rst}, rd);
      foreach (rows[i]) begin
         apb(1, pd_msg_pkg::cfg_off, {16'h0, rows[i].cfg});
         if (rows[i].tx) begin
            @(posedge pclk);
            tx_req <= 1'b1;
            tx_code <= rows[i].code;
            @(posedge pclk);
            tx_req <= 1'b0;
            @(negedge pclk);
            chk("tx_done", 32'h1, {31'h0, tx_done});
            chk("tx_ok", {31'h0, rows[i].res[0]}, {31'h0, tx_ok});
         end else begin
            i_pd_remote_port.send(rows[i].code, 1'b1, 1'b0, i % 3, r);
            chk("rsp", {23'h0, 1'b1, rows[i].res, rows[i].code},
                {23'h0, r});
         end
      end
      chk("gotomin pulses", 32'h1, n_gm);
      apb(1, pd_msg_pkg::cfg_off, 32'h0);
      i_pd_remote_port.send(pd_msg_pkg::m_get_snk_cap, 1'b0, 1'b0, 0, r);
      chk("mid-sequence", {23'h0, 1'b1, pd_msg_pkg::a_perr,
          pd_msg_pkg::m_get_snk_cap}, {23'h0, r});
      i_pd_remote_port.send(pd_msg_pkg::m_get_snk_cap, 1'b0, 1'b1, 0, r);
      chk("in sequence", {23'h0, 1'b1, pd_msg_pkg::a_handle,
          pd_msg_pkg::m_get_snk_cap}, {23'h0, r});
      apb(1, pd_msg_pkg::int_en_off, 32'h1f);
      apb(0, pd_msg_pkg::int_sta_off, 32'h0);
      chk("status", 32'h1f, rd);
      chk("irq", 32'h1, {31'h0, irq});
      apb(1, pd_msg_pkg::int_clr_off, 32'h1f);
      apb(0, pd_msg_pkg::int_clr_off, 32'h0);
      chk("clear reads", 32'h0, rd);
      apb(0, pd_msg_pkg::int_sta_off, 32'h0);
      chk("status cleared", 32'h0, rd);
      chk("irq cleared", 32'h0, {31'h0, irq});
      apb(1, pd_msg_pkg::int_en_off, 32'h1 << pd_msg_pkg::ev_reject);
      i_pd_remote_port.send(pd_msg_pkg::m_ping, 1'b1, 1'b0, 2, r);
      chk("irq masked", 32'h0, {31'h0, irq});
      i_pd_remote_port.send(pd_msg_pkg::m_get_snk_cap, 1'b1, 1'b0, 0, r);
      chk("irq enabled", 32'h1, {31'h0, irq});
      apb(1, pd_msg_pkg::last_off, 32'hffff_ffff);
      apb(0, pd_msg_pkg::last_off, 32'h0);
      chk("last answer", {23'h0, 1'b0, pd_msg_pkg::a_reject,
          pd_msg_pkg::m_get_snk_cap}, rd);
      apb(0, 8'h40, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      apb(1, pd_msg_pkg::cfg_off, 32'h000a);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("rsp in reset", 32'h0, {23'h0, rsp});
      chk("irq in reset", 32'h0, {31'h0, irq});
      presetn <= 1'b1;
      apb(0, pd_msg_pkg::cfg_off, 32'h0);
      chk("cfg after reset", 32'h0, rd);
      give_verdict();
   end
endmodule : pd_message_applicability_tb

// ===== pd_msg_pkg.sv
// Shared constants and types for the message applicability block
package pd_msg_pkg;

   // Register byte offsets
   localparam logic [7:0] cfg_off     = 8'h00;
   localparam logic [7:0] last_off    = 8'h04;
   localparam logic [7:0] int_sta_off = 8'h08;
   localparam logic [7:0] int_en_off  = 8'h0c;
   localparam logic [7:0] int_clr_off = 8'h10;

   // Reset values
   localparam logic [15:0] cfg_rst    = 16'h0000;
   localparam logic [4:0]  int_en_rst = 5'h00;

   // Interrupt bit positions
   localparam int ev_ignore = 0;
   localparam int ev_reject = 1;
   localparam int ev_nak    = 2;
   localparam int ev_perr   = 3;
   localparam int ev_txblk  = 4;
   localparam int ev_num    = 5;

   // Power role and data role encodings
   localparam logic [1:0] pwr_src = 2'h0;
   localparam logic [1:0] pwr_snk = 2'h1;
   localparam logic [1:0] pwr_drp = 2'h2;
   localparam logic [1:0] dat_dfp = 2'h0;
   localparam logic [1:0] dat_ufp = 2'h1;
   localparam logic [1:0] dat_drd = 2'h2;

   // Message and command codes seen on the request ports
   typedef enum logic [4:0] {
      m_goodcrc, m_gotomin, m_accept, m_reject, m_ping, m_ps_rdy,
      m_get_src_cap, m_get_snk_cap, m_pr_swap, m_wait, m_soft_reset,
      m_dr_swap, m_vconn_swap, m_src_cap, m_request, m_bist,
      m_snk_cap, v_disc_id, v_disc_svid, v_disc_modes, v_enter,
      v_exit, v_attention
   } msg_e;

   // Response chosen for a received message
   typedef enum logic [2:0] {
      a_handle, a_ignore, a_reject, a_nak, a_perr
   } act_e;

   // Port configuration, bits [15:0] of the configuration register
   typedef struct packed {
      logic       opt_tx;     // Optional transmits enabled
      logic       attn_rx;    // Attention accepted by a DFP
      logic       ident_rx;   // UFP answers identity discovery
      logic       ss_pins;    // Uses the high-speed pins
      logic       bfsk;       // Supply-line FSK signalling
      logic       host_multi; // Host with several downstream ports
      logic       hub_multi;  // Hub with several downstream ports
      logic       charging;   // Sink charges from delivered power
      logic       modal;      // Modal operation supported
      logic       cable;      // Acts as a cable plug
      logic       cur_ufp;    // Present data role of a dual-role port
      logic       cur_snk;    // Present power role of a dual-role port
      logic [1:0] data_role;
      logic [1:0] pwr_role;
   } cfg_s;

   // One received message
   typedef struct packed {
      logic valid;
      logic ready;     // Policy is in a ready state
      logic expected;  // Part of an ongoing sequence
      msg_e code;
   } rx_s;

   // Response to a received message
   typedef struct packed {
      logic valid;
      act_e act;
      msg_e code;
   } rsp_s;

endpackage : pd_msg_pkg

// ===== pd_remote_port.sv
// Model of the remote port that sends messages and collects the answers
`timescale 1ns/10ps
module pd_remote_port (
   input  wire logic             pclk,
   output pd_msg_pkg::rx_s       rx,
   input  wire pd_msg_pkg::rsp_s rsp
);
   initial begin
      rx = '0;
   end

   // Idle gap gives prompt and slow senders; released lines show inverses
   task automatic send(
      input  pd_msg_pkg::msg_e code,
      input  logic             rdy,
      input  logic             seq,
      input  int               gap,
      output pd_msg_pkg::rsp_s got
   );
      repeat (gap) @(posedge pclk);
      @(posedge pclk);
      rx <= '{1'b1, rdy, seq, code};
      @(posedge pclk);
      rx <= '{1'b0, ~rdy, ~seq, pd_msg_pkg::msg_e'(~code)};
      // Answer stands for one cycle after the taking edge; look mid-cycle
      @(negedge pclk);
      got = rsp;
   endtask : send
endmodule : pd_remote_port
